// >>> core/accel_cfg_map.vh
// Register map of the sensor configuration bank.
// Assumes word-wide APB access; byte address is four times each index.
`ifndef ACCEL_CFG_MAP_VH
`define ACCEL_CFG_MAP_VH

// Register indices
`define IDX_RATE_FILTER 8'h40
`define IDX_RANGE 8'h41
`define IDX_AUX_POLL 8'h44
`define IDX_DOWNSAMPLE 8'h45
`define IDX_THR_LOW 8'h46
`define IDX_THR_HIGH 8'h47
`define IDX_FILL_LOW 8'h24
`define IDX_FILL_HIGH 8'h25
`define IDX_IRQ_STATUS 8'h50
`define IDX_IRQ_MASK 8'h51

// Reset values
`define RST_RATE_FILTER 8'ha8
`define RST_RANGE 8'h01
`define RST_AUX_POLL 8'h46
`define RST_DOWNSAMPLE 8'h80
`define RST_THR_LOW 8'h00
`define RST_THR_HIGH 8'h02

// Writable bits
`define WMASK_RANGE 8'h03
`define WMASK_DOWNSAMPLE 8'hf0
`define WMASK_THR_HIGH 8'h1f
`define WMASK_IRQ 8'h03

// Field positions
`define PERF_BIT 7
`define BW_HI 6
`define BW_LO 4
`define RATE_HI 3
`define RATE_LO 0
`define FILT_BIT 7
`define DOWNS_HI 6
`define DOWNS_LO 4
`define IRQ_WTM_BIT 0
`define IRQ_CODE_BIT 1

// Rate and bandwidth code limits
`define ACCEL_RATE_MAX 4'hc
`define AUX_RATE_MAX 4'hb
`define BW_CONT_MAX 3'h2

// Timing: trigger offset step and clock rate
`define AUX_STEP_US 2500
`define CLOCK_MHZ 250

`endif

// >>> core/accel_cfg_regs.v
// Configuration register bank of a three-axis acceleration sensor, APB.
// Assumes fifo_fill and the sample and poll strobes are synchronous.

`include "accel_cfg_map.vh"

module accel_cfg_regs #(
	parameter ADDR_W = 12,
	parameter FILL_W = 14,
	parameter AUX_STEP_CYCLES = `AUX_STEP_US * `CLOCK_MHZ
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Interrupt
	output wire irq,
	// FIFO side
	input wire [FILL_W-1:0] fifo_fill,
	input wire accel_sample_valid,
	output reg fifo_write_strobe,
	output reg fifo_use_filtered,
	output reg watermark_reached,
	// Accelerometer filter and range control
	output reg [3:0] accel_rate_code,
	output reg accel_rate_valid,
	output reg continuous_filter,
	output reg four_times_oversample,
	output reg two_times_oversample,
	output reg normal_filter,
	output reg [2:0] average_log2,
	output reg bandwidth_valid,
	output reg [1:0] full_scale_code,
	// Auxiliary sensor sequencing
	input wire aux_poll_tick,
	output reg [3:0] aux_rate_code,
	output reg aux_rate_valid,
	output reg aux_trigger,
	output reg aux_readout
);

	localparam AUX_IDLE = 2'd0;
	localparam AUX_WAIT = 2'd1;
	localparam AUX_TRIG = 2'd2;
	// Step count cut to the counter width on purpose; 20 bits hold 2.5 ms
	localparam [31:0] STEP_FULL = AUX_STEP_CYCLES - 1;
	localparam [19:0] STEP_LAST = STEP_FULL[19:0];

	// Rate code usable: nonzero and not above the limit
	function rate_ok;
		input [3:0] code;
		input [3:0] max_code;
		begin
			rate_ok = (code != 4'h0) && (code <= max_code);
		end
	endfunction

	// Bandwidth code reserved: continuous mode above normal filtering
	function bw_reserved;
		input perf;
		input [2:0] bw;
		begin
			bw_reserved = perf && (bw > `BW_CONT_MAX);
		end
	endfunction

	// Continuous-mode filter selection matches the given code
	function cont_pick;
		input perf;
		input [2:0] bw;
		input [2:0] code;
		begin
			cont_pick = perf && (bw == code);
		end
	endfunction

	reg [7:0] rate_filter_q;
	reg [7:0] range_q;
	reg [7:0] aux_poll_q;
	reg [7:0] downsample_q;
	reg [7:0] thr_low_q;
	reg [7:0] thr_high_q;
	reg [7:0] irq_status_q;
	reg [7:0] irq_mask_q;
	reg [7:0] irq_status_d;
	reg wtm_level_q;
	reg [6:0] downs_cnt_q;
	reg [1:0] aux_state_q;
	reg [19:0] step_cnt_q;
	reg [3:0] steps_left_q;
	reg [7:0] rd_word;
	reg rd_hit;

	wire [7:0] idx;
	wire setup;
	wire wr_access;
	wire [7:0] wbyte;
	wire [12:0] watermark;
	wire wtm_level;
	wire bad_code_write;
	wire [6:0] downs_mask;
	wire [3:0] aux_offset;
	wire wtm_rise;
	wire [7:0] clear_bits;

	// Word index; the two low address bits are ignored
	assign idx = paddr[9:2];
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign wbyte = pwdata[7:0];
	// No wait states: every access ends after one access cycle
	assign pready = 1'b1;
	assign watermark = {thr_high_q[4:0], thr_low_q};
	assign wtm_level = ({{(FILL_W-13){1'b0}}, watermark} <= fifo_fill);
	assign aux_offset = aux_poll_q[7:4];
	assign irq = |(irq_status_q & irq_mask_q);
	// Only a fresh crossing sets the flag, so a clear is not undone at once
	assign wtm_rise = wtm_level && !wtm_level_q;
	assign clear_bits = (wr_access && idx == `IDX_IRQ_STATUS) ?
		(wbyte & `WMASK_IRQ) : 8'h00;

	// Write of a reserved rate or bandwidth code to either config register
	assign bad_code_write = wr_access && (
		(idx == `IDX_RATE_FILTER && (!rate_ok(wbyte[3:0], `ACCEL_RATE_MAX) ||
			bw_reserved(wbyte[`PERF_BIT], wbyte[6:4]))) ||
		(idx == `IDX_AUX_POLL && !rate_ok(wbyte[3:0], `AUX_RATE_MAX)));

	// Read decode
	always @* begin
		rd_hit = 1'b1;
		rd_word = 8'h00;
		case (idx)
			`IDX_RATE_FILTER: rd_word = rate_filter_q;
			`IDX_RANGE: rd_word = range_q;
			`IDX_AUX_POLL: rd_word = aux_poll_q;
			`IDX_DOWNSAMPLE: rd_word = downsample_q;
			`IDX_THR_LOW: rd_word = thr_low_q;
			`IDX_THR_HIGH: rd_word = thr_high_q;
			`IDX_FILL_LOW: rd_word = fifo_fill[7:0];
			`IDX_FILL_HIGH: rd_word = {2'b00, fifo_fill[13:8]};
			`IDX_IRQ_STATUS: rd_word = irq_status_q;
			`IDX_IRQ_MASK: rd_word = irq_mask_q;
			default: rd_hit = 1'b0;
		endcase
	end

	reg hit_q;
	assign pslverr = psel && penable && !hit_q;

	// Read data is captured in the setup cycle, valid in access
	always @(posedge clock) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_word};
		end
	end

	// Unmapped index remembered for the error answer in access
	always @(posedge clock) begin
		if (!rst_b) begin
			hit_q <= 1'b0;
		end else if (setup) begin
			hit_q <= rd_hit;
		end
	end

	// Configuration registers; reserved codes are kept and flagged
	always @(posedge clock) begin
		if (!rst_b) begin
			rate_filter_q <= `RST_RATE_FILTER;
			range_q <= `RST_RANGE;
			aux_poll_q <= `RST_AUX_POLL;
			downsample_q <= `RST_DOWNSAMPLE;
			thr_low_q <= `RST_THR_LOW;
			thr_high_q <= `RST_THR_HIGH;
			irq_mask_q <= 8'h00;
		end else if (wr_access) begin
			case (idx)
				`IDX_RATE_FILTER: rate_filter_q <= wbyte;
				`IDX_RANGE: range_q <= wbyte & `WMASK_RANGE;
				`IDX_AUX_POLL: aux_poll_q <= wbyte;
				`IDX_DOWNSAMPLE:
					downsample_q <= wbyte & `WMASK_DOWNSAMPLE;
				`IDX_THR_LOW: thr_low_q <= wbyte;
				`IDX_THR_HIGH:
					thr_high_q <= wbyte & `WMASK_THR_HIGH;
				`IDX_IRQ_MASK: irq_mask_q <= wbyte & `WMASK_IRQ;
				default: ;
			endcase
		end
	end

	// Sticky status: set wins over write-one-to-clear
	always @* begin
		irq_status_d = irq_status_q & ~clear_bits;
		if (wtm_rise)
			irq_status_d[`IRQ_WTM_BIT] = 1'b1;
		if (bad_code_write)
			irq_status_d[`IRQ_CODE_BIT] = 1'b1;
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			irq_status_q <= 8'h00;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	// Watermark level, registered for the edge detector and the output
	always @(posedge clock) begin
		if (!rst_b) begin
			wtm_level_q <= 1'b0;
			watermark_reached <= 1'b0;
		end else begin
			wtm_level_q <= wtm_level;
			watermark_reached <= wtm_level;
		end
	end

	// Decoded accelerometer controls; they settle one clock after a write
	always @(posedge clock) begin
		if (!rst_b) begin
			accel_rate_code <= 4'h0;
			accel_rate_valid <= 1'b0;
			continuous_filter <= 1'b0;
			four_times_oversample <= 1'b0;
			two_times_oversample <= 1'b0;
			normal_filter <= 1'b0;
			average_log2 <= 3'h0;
			bandwidth_valid <= 1'b0;
		end else begin
			accel_rate_code <= rate_filter_q[`RATE_HI:`RATE_LO];
			accel_rate_valid <= rate_ok(rate_filter_q[3:0],
				`ACCEL_RATE_MAX);
			continuous_filter <= rate_filter_q[`PERF_BIT];
			four_times_oversample <= cont_pick(rate_filter_q[`PERF_BIT],
				rate_filter_q[6:4], 3'h0);
			two_times_oversample <= cont_pick(rate_filter_q[`PERF_BIT],
				rate_filter_q[6:4], 3'h1);
			normal_filter <= cont_pick(rate_filter_q[`PERF_BIT],
				rate_filter_q[6:4], 3'h2);
			// Averaging depth forced to none in continuous mode
			average_log2 <= rate_filter_q[`PERF_BIT] ? 3'h0 :
				rate_filter_q[`BW_HI:`BW_LO];
			bandwidth_valid <= !bw_reserved(rate_filter_q[`PERF_BIT],
				rate_filter_q[6:4]);
		end
	end

	// Range, auxiliary rate and FIFO data selection
	always @(posedge clock) begin
		if (!rst_b) begin
			full_scale_code <= 2'h0;
			aux_rate_code <= 4'h0;
			aux_rate_valid <= 1'b0;
			fifo_use_filtered <= 1'b0;
		end else begin
			full_scale_code <= range_q[1:0];
			aux_rate_code <= aux_poll_q[3:0];
			// Reserved poll codes are stored but never start a poll
			aux_rate_valid <= rate_ok(aux_poll_q[3:0],
				`AUX_RATE_MAX);
			fifo_use_filtered <= downsample_q[`FILT_BIT];
		end
	end

	// FIFO downsampling: pass one sample in 2**n
	// Counter advances only on valid samples and starts at zero, so the first sample after reset passes
	assign downs_mask = (7'h7f >> (3'h7 - downsample_q[`DOWNS_HI:`DOWNS_LO]));

	always @(posedge clock) begin
		if (!rst_b) begin
			downs_cnt_q <= 7'h00;
			fifo_write_strobe <= 1'b0;
		end else begin
			fifo_write_strobe <= 1'b0;
			if (accel_sample_valid) begin
				fifo_write_strobe <= ((downs_cnt_q & downs_mask) ==
					7'h00);
				downs_cnt_q <= downs_cnt_q + 7'h01;
			end
		end
	end

	// Auxiliary trigger and readout sequencing
	// Poll ticks arriving while a wait runs are dropped
	always @(posedge clock) begin
		if (!rst_b) begin
			aux_state_q <= AUX_IDLE;
			step_cnt_q <= 20'h0_0000;
			steps_left_q <= 4'h0;
			aux_trigger <= 1'b0;
			aux_readout <= 1'b0;
		end else begin
			aux_trigger <= 1'b0;
			aux_readout <= 1'b0;
			case (aux_state_q)
				AUX_IDLE: begin
					if (aux_poll_tick && aux_rate_valid) begin
						if (aux_offset == 4'h0) begin
							aux_readout <= 1'b1;
							aux_state_q <= AUX_TRIG;
						end else begin
							aux_trigger <= 1'b1;
							steps_left_q <= aux_offset;
							step_cnt_q <= 20'h0_0000;
							aux_state_q <= AUX_WAIT;
						end
					end
				end
				AUX_WAIT: begin
					if (step_cnt_q == STEP_LAST) begin
						step_cnt_q <= 20'h0_0000;
						steps_left_q <= steps_left_q - 4'h1;
						if (steps_left_q == 4'h1) begin
							aux_readout <= 1'b1;
							aux_state_q <= AUX_IDLE;
						end
					end else begin
						step_cnt_q <= step_cnt_q + 20'h0_0001;
					end
				end
				// Offset zero: readout came first, trigger follows at once
				AUX_TRIG: begin
					aux_trigger <= 1'b1;
					aux_state_q <= AUX_IDLE;
				end
				default: aux_state_q <= AUX_IDLE;
			endcase
		end
	end

endmodule // accel_cfg_regs

// >>> sim/accel_cfg_checker.sv
// Assertions on the ports of the configuration bank.
// Assumes one clock domain with a synchronous active-low reset.
module accel_cfg_checker #(
	parameter FILL_W = 14
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Bus
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pslverr,
	// FIFO side
	input wire [FILL_W-1:0] fifo_fill,
	input wire accel_sample_valid,
	input wire fifo_write_strobe,
	input wire watermark_reached,
	// Filter control
	input wire [3:0] accel_rate_code,
	input wire accel_rate_valid,
	input wire continuous_filter,
	input wire four_times_oversample,
	input wire two_times_oversample,
	input wire normal_filter,
	input wire [2:0] average_log2,
	input wire bandwidth_valid,
	// Auxiliary
	input wire [3:0] aux_rate_code,
	input wire aux_rate_valid,
	input wire aux_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence pulse_s(s);
		s ##1 !s;
	endsequence
	sequence filt_s;
		four_times_oversample || two_times_oversample || normal_filter;
	endsequence
	ro_upper_a: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	strobe_cause_a: assert property (
		fifo_write_strobe |-> $past(accel_sample_valid))
		else $error("strobe without sample");
	trig_pulse_a: assert property (aux_trigger |-> pulse_s(aux_trigger))
		else $error("trigger longer than one cycle");
	wtm_full_a: assert property ($past(rst_b) &&
		$past(fifo_fill) == {FILL_W{1'b1}} |-> watermark_reached)
		else $error("full fill not reached");
	cont_modes_a: assert property (filt_s |-> continuous_filter &&
		$onehot({four_times_oversample, two_times_oversample, normal_filter}))
		else $error("filter modes inconsistent");
	avg_zero_a: assert property (continuous_filter |-> average_log2 == 3'h0)
		else $error("averaging in continuous mode");
	bw_res_a: assert property (continuous_filter &&
		!(four_times_oversample || two_times_oversample || normal_filter)
		|-> !bandwidth_valid)
		else $error("reserved bandwidth valid");
	avg_valid_a: assert property ($past(rst_b) && !continuous_filter
		|-> bandwidth_valid)
		else $error("averaging code invalid");
	rate_valid_a: assert property (
		accel_rate_valid == (accel_rate_code inside {[4'h1:4'hc]}))
		else $error("rate valid wrong");
	aux_valid_a: assert property (
		aux_rate_valid == (aux_rate_code inside {[4'h1:4'hb]}))
		else $error("aux rate valid wrong");
endmodule // accel_cfg_checker

bind accel_cfg_regs accel_cfg_checker #(.FILL_W(FILL_W)) checker_i (.*);

// >>> sim/apb_host.sv
// Host model issuing single APB transfers to the bank.
// Assumes pready is sampled at rising edges; waits are bounded.
module apb_host (
	// Bus inputs
	input wire logic clock,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Bus outputs
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hung = 1'b0;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hung |= (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host

// >>> sim/accel_aux_fifo_config_regs_tb.sv
// Self-checking bench for the configuration bank.
// Assumes the host model and checker compile alongside.
`include "accel_cfg_map.vh"
module accel_aux_fifo_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 8;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [13:0] fifo_fill;
	logic accel_sample_valid, fifo_write_strobe, fifo_use_filtered;
	logic watermark_reached, accel_rate_valid, continuous_filter, e;
	logic four_times_oversample, two_times_oversample, normal_filter;
	logic bandwidth_valid, aux_poll_tick, aux_rate_valid;
	logic aux_trigger, aux_readout;
	logic [3:0] accel_rate_code, aux_rate_code;
	logic [2:0] average_log2;
	logic [1:0] full_scale_code;
	logic [7:0] n;
	int bad_count = 0;
	int checks_done = 0;
	accel_cfg_regs #(.AUX_STEP_CYCLES(STEP)) DUT (.*);
	apb_host host (.*);
	task automatic report_and_stop;
		bad_count += host.hung;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, got);
		checks_done++;
		if (got !== x) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, got);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		host.xfer(1'b1, {2'b0, i, 2'b0}, {24'h0, d}, q, e);
		if (host.hung) report_and_stop();
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] x);
		host.xfer(1'b0, {2'b0, i, 2'b0}, 32'h0, q, e);
		if (host.hung) report_and_stop();
		chk("read", {24'h0, x}, q);
	endtask
	task automatic lag;
		repeat (2) @(negedge clock);
	endtask
	task automatic t_reset;
		rd(`IDX_RATE_FILTER, 8'ha8);
		rd(`IDX_RANGE, 8'h01);
		rd(`IDX_AUX_POLL, 8'h46);
		rd(`IDX_DOWNSAMPLE, 8'h80);
		rd(`IDX_THR_LOW, 8'h00);
		rd(`IDX_THR_HIGH, 8'h02);
		chk("decode", 13'b1000_1_1_01_0110_1, {accel_rate_code, continuous_filter,
			normal_filter, full_scale_code, aux_rate_code, fifo_use_filtered});
	endtask
	task automatic t_reserved;
		wr(`IDX_RANGE, 8'hff);
		rd(`IDX_RANGE, 8'h03);
		wr(`IDX_DOWNSAMPLE, 8'hff);
		rd(`IDX_DOWNSAMPLE, 8'hf0);
		wr(`IDX_THR_HIGH, 8'hff);
		rd(`IDX_THR_HIGH, 8'h1f);
	endtask
	task automatic t_modes;
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 8; b++) begin
				wr(`IDX_RATE_FILTER, {p[0], b[2:0], 4'h8});
				lag;
				chk("bw", {p[0], p == 1 && b == 0, p == 1 && b == 1,
					p == 1 && b == 2, p ? 3'h0 : b[2:0], !(p == 1 && b > 2)},
					{continuous_filter, four_times_oversample, two_times_oversample,
					normal_filter, average_log2, bandwidth_valid});
			end
		end
		for (int c = 0; c < 16; c++) begin
			wr(`IDX_RATE_FILTER, {4'h2, c[3:0]});
			wr(`IDX_AUX_POLL, {4'h3, c[3:0]});
			wr(`IDX_RANGE, {6'h0, c[1:0]});
			lag;
			chk("rate", {c[3:0], c >= 1 && c <= 12, c[3:0], c >= 1 && c <= 11,
				c[1:0]}, {accel_rate_code, accel_rate_valid, aux_rate_code,
				aux_rate_valid, full_scale_code});
		end
	endtask
	task automatic t_fill_irq;
		@(posedge clock);
		fifo_fill <= 14'h3fff;
		rd(`IDX_FILL_LOW, 8'hff);
		rd(`IDX_FILL_HIGH, 8'h3f);
		wr(`IDX_THR_LOW, 8'h05);
		wr(`IDX_THR_HIGH, 8'h01);
		@(posedge clock);
		fifo_fill <= 14'h0104;
		lag;
		wr(`IDX_IRQ_STATUS, 8'h03);
		rd(`IDX_IRQ_STATUS, 8'h00);
		chk("below", 2'b00, {watermark_reached, irq});
		@(posedge clock);
		fifo_fill <= 14'h0105;
		lag;
		chk("masked", 2'b10, {watermark_reached, irq});
		wr(`IDX_IRQ_MASK, 8'h01);
		lag;
		chk("irq", 1'b1, irq);
		rd(`IDX_IRQ_STATUS, 8'h01);
		wr(`IDX_IRQ_STATUS, 8'h01);
		lag;
		chk("cleared", 1'b0, irq);
		host.xfer(1'b0, 12'h3fc, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
	endtask
	task automatic t_downs;
		wr(`IDX_DOWNSAMPLE, 8'h90);
		n = 0;
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			accel_sample_valid <= 1'b1;
			@(posedge clock);
			accel_sample_valid <= 1'b0;
			@(negedge clock);
			n += fifo_write_strobe;
		end
		chk("strobes", 8'd2, n);
		chk("filtered", 1'b1, fifo_use_filtered);
		wr(`IDX_DOWNSAMPLE, 8'h00);
		lag;
		chk("unfiltered", 1'b0, fifo_use_filtered);
	endtask
	task automatic t_aux(input logic [3:0] off, input int tt, tr);
		int ft, fr;
		wr(`IDX_AUX_POLL, {off, 4'h6});
		@(posedge clock);
		aux_poll_tick <= 1'b1;
		@(posedge clock);
		aux_poll_tick <= 1'b0;
		ft = 0;
		fr = 0;
		for (int i = 1; i < 40; i++) begin
			@(negedge clock);
			if (aux_trigger === 1'b1 && ft == 0)
				ft = i;
			if (aux_readout === 1'b1 && fr == 0)
				fr = i;
		end
		chk("trigger", tt, ft);
		chk("readout", tr, fr);
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		rst_b = 1'b0;
		fifo_fill = 14'h0;
		accel_sample_valid = 1'b0;
		aux_poll_tick = 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_reserved();
		t_modes();
		t_fill_irq();
		t_downs();
		t_aux(4'h1, 1, 1 + STEP);
		t_aux(4'h2, 1, 1 + 2 * STEP);
		t_aux(4'h0, 2, 1);
		report_and_stop();
	end
endmodule // accel_aux_fifo_config_regs_tb
